// File: include/hsf_pkg.sv
// Shared constants and types of the hot swap fault sequencer
package hsf_pkg;

    // Reference clock rate, cycles per microsecond
    localparam int unsigned CLK_PER_US      = 100;

    // Filter and delay times in microseconds
    localparam int unsigned SUPPLY_FILT_US  = 1000;
    localparam int unsigned SHUTOFF_FILT_US = 1000;
    localparam int unsigned THERM_FILT_US   = 12;
    localparam int unsigned OVERCUR_FILT_US = 3000;
    localparam int unsigned STARTUP_US      = 200000;
    localparam int unsigned PWR_OK_DLY_US   = 20000;

    // Same times as clock cycle counts
    localparam int unsigned SUPPLY_FILT_CYC  = SUPPLY_FILT_US * CLK_PER_US;
    localparam int unsigned SHUTOFF_FILT_CYC = SHUTOFF_FILT_US * CLK_PER_US;
    localparam int unsigned THERM_FILT_CYC   = THERM_FILT_US * CLK_PER_US;
    localparam int unsigned OVERCUR_FILT_CYC = OVERCUR_FILT_US * CLK_PER_US;
    localparam int unsigned STARTUP_CYC      = STARTUP_US * CLK_PER_US;
    localparam int unsigned PWR_OK_DLY_CYC   = PWR_OK_DLY_US * CLK_PER_US;

    // Retry counter
    localparam int unsigned RETRY_W     = 4;
    localparam logic [3:0]  RETRY_LIMIT = 4'hA;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;

    // Status register fields
    localparam int unsigned ST_STATE_LSB  = 0;
    localparam int unsigned ST_GATE_BIT   = 4;
    localparam int unsigned ST_PWROK_BIT  = 5;
    localparam int unsigned ST_LOW_BIT    = 8;
    localparam int unsigned ST_HIGH_BIT   = 9;
    localparam int unsigned ST_HOT_BIT    = 10;
    localparam int unsigned ST_OVC_BIT    = 11;
    localparam int unsigned ST_OFF_BIT    = 12;
    localparam int unsigned ST_LOCK_BIT   = 13;
    localparam int unsigned ST_RETRY_LSB  = 16;

    // Control register fields
    localparam int unsigned CTL_SOFT_OFF_BIT = 0;

    // Sequencer states
    typedef enum logic [2:0] {
        HSF_STARTUP,
        HSF_CHARGING,
        HSF_PWROK_DELAY,
        HSF_NORMAL
    } hsf_state_e;

endpackage : hsf_pkg

// File: rtl/hsf_persist_filter.sv
// Persistence filter: output follows input only after a held change
`timescale 1ns/1ps
`default_nettype none
module hsf_persist_filter #(
    parameter int unsigned HOLD_CYC = 100
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // Raw and filtered level
    input  wire logic i_raw,
    output logic      o_level
);

    // Whole state of the filter
    typedef struct packed {
        logic        level;   // Accepted level
        logic [31:0] cnt;     // Cycles the raw level has differed
    } hsf_filt_s;

    hsf_filt_s s;
    hsf_filt_s next_s;

    // Count only while raw differs; any return restarts the count
    always_comb begin
        next_s = s;
        if (i_raw == s.level) begin
            next_s.cnt = '0;
        end else if (s.cnt >= 32'(HOLD_CYC - 1)) begin
            next_s.level = i_raw;
            next_s.cnt   = '0;
        end else begin
            next_s.cnt = s.cnt + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_level = s.level;

endmodule : hsf_persist_filter
`default_nettype wire

// File: rtl/hsf_sequencer.sv
// Hot swap fault sequencer with AHB-Lite status and control registers
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Supply range faults act after 1.0 ms
// - Supply in range permits gate on
// - Range fault: gate off, power ok off, restart
// - Range checked during start-up and afterwards
// - One 200 ms start-up delay timer
// - Same timer gives the retry delay
// - Power ok after full enhancement plus 20 ms
// - Complementary power ok outputs always agree
// - Shutoff held 1.0 ms drops power ok
// - Over-temperature held 12 us drops power ok
// - Overcurrent held 3.0 ms drops power ok
// - Power-up waits while shutoff is active
// - Shutoff clears retries, gate off, power ok off
// - Shutoff acted on after 1.0 ms
// - Gate on after delay if retries below 10
// - Normal operation clears the retry counter
// - Shutoff released 1.0 ms starts new sequence
module hsf_sequencer
    import hsf_pkg::*;
#(
    parameter int unsigned SUPPLY_FILT  = SUPPLY_FILT_CYC,
    parameter int unsigned SHUTOFF_FILT = SHUTOFF_FILT_CYC,
    parameter int unsigned THERM_FILT   = THERM_FILT_CYC,
    parameter int unsigned OVERCUR_FILT = OVERCUR_FILT_CYC,
    parameter int unsigned STARTUP_DLY  = STARTUP_CYC,
    parameter int unsigned PWR_OK_DLY   = PWR_OK_DLY_CYC
) (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Comparator and fault inputs
    input  wire logic        i_supply_lockout_ok,
    input  wire logic        i_low_supply_fault,
    input  wire logic        i_high_supply_fault,
    input  wire logic        i_over_temp,
    input  wire logic        i_over_current,
    input  wire logic        i_fully_enhanced,
    // Shutoff request
    input  wire logic        i_shutoff_req,
    // Gate command and power ok outputs
    output logic             o_gate_on,
    output logic             o_power_ok,
    output logic             o_power_ok_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata
);

    // Whole state of the sequencer and bus slave
    typedef struct packed {
        hsf_state_e          state;     // Sequencer state
        logic                gate;      // Pass transistor command
        logic                pwr_ok;    // Power ok, active high
        logic                pwr_ok_n;  // Power ok, active low
        logic [31:0]         timer;     // Shared delay timer
        logic [RETRY_W-1:0]  retry;     // Retry counter
        logic                powerup;   // Still in first power-up
        logic                soft_off;  // Software shutoff request
        logic                dph_wr;    // Write data phase pending
        logic [7:0]          dph_addr;  // Address of that write
        logic                hready;    // Bus ready
        logic                hresp;     // Bus response
        logic [31:0]         hrdata;    // Read data
    } hsf_seq_s;

    // Values after reset
    localparam hsf_seq_s RESET_S = '{
        state:    HSF_STARTUP,
        gate:     1'b0,
        pwr_ok:   1'b0,
        pwr_ok_n: 1'b1,
        timer:    32'h0000_0000,
        retry:    4'h0,
        powerup:  1'b1,
        soft_off: 1'b0,
        dph_wr:   1'b0,
        dph_addr: 8'h00,
        hready:   1'b1,
        hresp:    1'b0,
        hrdata:   32'h0000_0000
    };

    hsf_seq_s s;
    hsf_seq_s next_s;

    // Filtered fault levels
    logic low_f;    // Undervoltage persisted
    logic high_f;   // Overvoltage persisted
    logic hot_f;    // Over-temperature persisted
    logic ovc_f;    // Overcurrent persisted
    logic off_f;    // Shutoff persisted
    logic off_raw;  // Pin or software shutoff
    logic ovc_raw;  // Overcurrent only counts with gate on

    assign off_raw = i_shutoff_req | s.soft_off;
    assign ovc_raw = i_over_current & s.gate;

    // Supply range filters, both ways 1.0 ms
    hsf_persist_filter #(.HOLD_CYC(SUPPLY_FILT)) u_low_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_raw     (i_low_supply_fault),
        .o_level   (low_f)
    );
    hsf_persist_filter #(.HOLD_CYC(SUPPLY_FILT)) u_high_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_raw     (i_high_supply_fault),
        .o_level   (high_f)
    );

    // Thermal filter, 12 us
    hsf_persist_filter #(.HOLD_CYC(THERM_FILT)) u_hot_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_raw     (i_over_temp),
        .o_level   (hot_f)
    );

    // Overcurrent filter, 3.0 ms
    hsf_persist_filter #(.HOLD_CYC(OVERCUR_FILT)) u_ovc_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_raw     (ovc_raw),
        .o_level   (ovc_f)
    );

    // Shutoff filter, 1.0 ms on both edges
    hsf_persist_filter #(.HOLD_CYC(SHUTOFF_FILT)) u_off_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_raw     (off_raw),
        .o_level   (off_f)
    );

    // Start-up conditions, checked in every state
    logic cond_ok;
    assign cond_ok = i_supply_lockout_ok & ~low_f & ~high_f & ~hot_f & ~off_f;

    // Any reason to drop the gate once started
    logic trip;
    assign trip = ~cond_ok | ovc_f;

    // Status word assembled from live state
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_STATE_LSB +: 3]       = s.state;
        status_word[ST_GATE_BIT]             = s.gate;
        status_word[ST_PWROK_BIT]            = s.pwr_ok;
        status_word[ST_LOW_BIT]              = low_f;
        status_word[ST_HIGH_BIT]             = high_f;
        status_word[ST_HOT_BIT]              = hot_f;
        status_word[ST_OVC_BIT]              = ovc_f;
        status_word[ST_OFF_BIT]              = off_f;
        status_word[ST_LOCK_BIT]             = i_supply_lockout_ok;
        status_word[ST_RETRY_LSB +: RETRY_W] = s.retry;
    end

    // Next state of sequencer and bus slave
    always_comb begin
        next_s = s;

        // First power-up ends once the raw request is seen released
        if (!off_raw) begin
            next_s.powerup = 1'b0;
        end

        // A held shutoff keeps the retry count cleared
        if (off_f) begin
            next_s.retry = '0;
        end

        case (s.state)
            // Gate off; timer runs only while all conditions hold
            HSF_STARTUP: begin
                next_s.gate   = 1'b0;
                next_s.pwr_ok = 1'b0;
                if (s.powerup && off_raw) begin
                    next_s.timer = '0;
                end else if (!cond_ok) begin
                    next_s.timer = '0;
                end else if (s.timer >= 32'(STARTUP_DLY - 1)) begin
                    // Too many retries: wait here for a shutoff cycle
                    if (s.retry < RETRY_LIMIT) begin
                        next_s.state = HSF_CHARGING;
                        next_s.gate  = 1'b1;
                        next_s.timer = '0;
                    end
                end else begin
                    next_s.timer = s.timer + 32'h0000_0001;
                end
            end
            // Gate on, waiting for full enhancement
            HSF_CHARGING: begin
                if (trip) begin
                    next_s.state = HSF_STARTUP;
                end else if (i_fully_enhanced) begin
                    next_s.state = HSF_PWROK_DELAY;
                    next_s.timer = '0;
                end
            end
            // Enhanced; power ok after the nominal delay
            HSF_PWROK_DELAY: begin
                if (trip) begin
                    next_s.state = HSF_STARTUP;
                end else if (!i_fully_enhanced) begin
                    next_s.state = HSF_CHARGING;
                    next_s.timer = '0;
                end else if (s.timer >= 32'(PWR_OK_DLY - 1)) begin
                    next_s.state    = HSF_NORMAL;
                    next_s.pwr_ok   = 1'b1;
                    next_s.retry    = '0;
                    next_s.timer    = '0;
                end else begin
                    next_s.timer = s.timer + 32'h0000_0001;
                end
            end
            // Normal operation, any filtered fault drops out
            HSF_NORMAL: begin
                if (trip) begin
                    next_s.state = HSF_STARTUP;
                end
            end
            default: begin
                next_s.state = HSF_STARTUP;
            end
        endcase

        // Drop out: gate off, power ok off, retry delay restarts
        if (s.state != HSF_STARTUP && trip) begin
            next_s.gate   = 1'b0;
            next_s.pwr_ok = 1'b0;
            next_s.timer  = '0;
            if (off_f) begin
                next_s.retry = '0;
            end else if (s.retry < RETRY_LIMIT) begin
                next_s.retry = s.retry + 4'h1;
            end
        end

        // Low output is always the inverse of the high one
        next_s.pwr_ok_n = ~next_s.pwr_ok;

        // Bus: zero wait states, always OKAY
        next_s.hready = 1'b1;
        next_s.hresp  = 1'b0;
        next_s.dph_wr = 1'b0;

        // Data phase of a write lands here
        if (s.dph_wr) begin
            if (s.dph_addr == OFS_CONTROL) begin
                next_s.soft_off = i_hwdata[CTL_SOFT_OFF_BIT];
            end
        end

        // Address phase; read data registered for the data phase
        if (i_hsel && i_hready && i_htrans[1]) begin
            next_s.dph_addr = i_haddr[7:0];
            next_s.dph_wr   = i_hwrite;
            if (!i_hwrite) begin
                if (i_haddr[7:0] == OFS_STATUS) begin
                    next_s.hrdata = status_word;
                end else if (i_haddr[7:0] == OFS_CONTROL) begin
                    next_s.hrdata = {31'h0000_0000, s.soft_off};
                end else begin
                    // Unmapped reads return zero
                    next_s.hrdata = 32'h0000_0000;
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s <= RESET_S;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign o_gate_on    = s.gate;
    assign o_power_ok   = s.pwr_ok;
    assign o_power_ok_n = s.pwr_ok_n;
    assign o_hreadyout  = s.hready;
    assign o_hresp      = s.hresp;
    assign o_hrdata     = s.hrdata;

endmodule : hsf_sequencer
`default_nettype wire

// File: testbench/hsf_load_model.sv
// Pass device and load model on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module hsf_load_model (
    // Clock
    input  wire logic i_sys_clk,
    // Gate command from the sequencer
    input  wire logic i_gate_on,
    // Test knobs: slow charge, never enhances
    input  wire logic i_slow,
    input  wire logic i_stuck,
    // Enhancement report back to the sequencer
    output logic      o_fully_enhanced
);
    logic [7:0] ramp; // Cycles since the gate turned on
    // Load charges while the gate is on; saturates so it never wraps
    always_ff @(posedge i_sys_clk) begin
        if (!i_gate_on) begin
            ramp <= 8'h00;
        end else if (ramp != 8'hFF) begin
            ramp <= ramp + 8'h01;
        end
    end
    // Slow loads take ten times longer to reach full enhancement
    assign o_fully_enhanced = i_gate_on && !i_stuck && (ramp >= (i_slow ? 8'h28 : 8'h04));
endmodule : hsf_load_model
`default_nettype wire

// File: testbench/hsf_sequencer_chk.sv
// Port assertions for the hot swap fault sequencer
`timescale 1ns/1ps
`default_nettype none
module hsf_sequencer_chk #(
    parameter int unsigned SUPPLY_FILT  = 10,
    parameter int unsigned SHUTOFF_FILT = 10,
    parameter int unsigned OVERCUR_FILT = 20,
    parameter int unsigned STARTUP_DLY  = 50,
    parameter int unsigned PWR_OK_DLY   = 20
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Watched inputs
    input wire logic i_low_supply_fault,
    input wire logic i_high_supply_fault,
    input wire logic i_over_current,
    input wire logic i_fully_enhanced,
    input wire logic i_shutoff_req,
    // Watched outputs
    input wire logic o_gate_on,
    input wire logic o_power_ok,
    input wire logic o_power_ok_n
);
    int unsigned off_n, enh_n, sh_n, sup_n, oc_n; // Run lengths in cycles
    // Consecutive cycles of each watched condition
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            off_n <= 0;
            enh_n <= 0;
            sh_n  <= 0;
            sup_n <= 0;
            oc_n  <= 0;
        end else begin
            off_n <= o_gate_on ? 0 : off_n + 1;
            enh_n <= (i_fully_enhanced && o_gate_on) ? enh_n + 1 : 0;
            sh_n  <= i_shutoff_req ? sh_n + 1 : 0;
            sup_n <= (i_low_supply_fault || i_high_supply_fault) ? sup_n + 1 : 0;
            oc_n  <= (i_over_current && o_gate_on) ? oc_n + 1 : 0;
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // Enhancement starts, then power ok must stay low for 8 cycles
    sequence s_enh_rise;
        $rose(i_fully_enhanced);
    endsequence
    sequence s_pok_low;
        !o_power_ok [*8];
    endsequence
    pok_pair_a: assert property (o_power_ok_n == !o_power_ok)
        else $error("Power ok pair disagrees");
    drop_both_a: assert property ($fell(o_gate_on) |-> !o_power_ok)
        else $error("Power ok outlived the gate");
    pok_wait_a: assert property (s_enh_rise |-> s_pok_low)
        else $error("Power ok too soon");
    pok_delay_a: assert property ($rose(o_power_ok) |-> enh_n >= PWR_OK_DLY)
        else $error("Power ok before its delay");
    start_wait_a: assert property ($rose(o_gate_on) |-> off_n >= STARTUP_DLY - 1)
        else $error("Gate on before start-up delay");
    shut_drop_a: assert property (sh_n >= SHUTOFF_FILT + 4 |-> !o_gate_on && !o_power_ok)
        else $error("Shutoff not obeyed");
    supply_drop_a: assert property (sup_n >= SUPPLY_FILT + 4 |-> !o_gate_on)
        else $error("Supply fault not obeyed");
    ovc_drop_a: assert property (oc_n <= OVERCUR_FILT + 4)
        else $error("Overcurrent not obeyed");
endmodule : hsf_sequencer_chk
bind hsf_sequencer hsf_sequencer_chk #(.SUPPLY_FILT(SUPPLY_FILT), .SHUTOFF_FILT(SHUTOFF_FILT),
    .OVERCUR_FILT(OVERCUR_FILT), .STARTUP_DLY(STARTUP_DLY), .PWR_OK_DLY(PWR_OK_DLY)) u_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_low_supply_fault(i_low_supply_fault),
    .i_high_supply_fault(i_high_supply_fault), .i_over_current(i_over_current),
    .i_fully_enhanced(i_fully_enhanced), .i_shutoff_req(i_shutoff_req),
    .o_gate_on(o_gate_on), .o_power_ok(o_power_ok), .o_power_ok_n(o_power_ok_n));
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the hot swap fault sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int SD = 50; // Short start-up delay
    logic        clk, rst, lock_ok, low_f, high_f, hot, ovc, shut, slow, stuck;
    logic        hwrite, hrdy, hresp, gate, pok, pok_n, enh, hsel;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          num_errors = 0;
    int          compares   = 0;
    int          cyc        = 0; // Free-running edge count for gap checks
    hsf_sequencer #(.SUPPLY_FILT(10), .SHUTOFF_FILT(10), .THERM_FILT(5),
        .OVERCUR_FILT(20), .STARTUP_DLY(SD), .PWR_OK_DLY(20)) u_dut (
        .i_sys_clk(clk), .i_rst(rst), .i_supply_lockout_ok(lock_ok),
        .i_low_supply_fault(low_f), .i_high_supply_fault(high_f),
        .i_over_temp(hot), .i_over_current(ovc), .i_fully_enhanced(enh),
        .i_shutoff_req(shut), .o_gate_on(gate), .o_power_ok(pok),
        .o_power_ok_n(pok_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata));
    hsf_load_model u_load (.i_sys_clk(clk), .i_gate_on(gate), .i_slow(slow),
        .i_stuck(stuck), .o_fully_enhanced(enh));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Retry gaps are timed against this; the start gap in t_powerup uses the wait loop count
    always @(posedge clk) cyc <= cyc + 1;
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Bounded wait for the gate (s=0) or power ok (s=1) to reach a level
    task automatic wait_for(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (((s == 0) ? gate : pok) !== v) begin
            @(posedge clk);
            n++;
            if (n > lim) begin
                check("wait", n, 0);
                wrap_up();
            end
        end
    endtask : wait_for
    // One AHB-Lite single word transfer; hsel is left as the caller set it, idle is htrans 0
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n;
        n = 0;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 40);
        // A slave that never answers ends the run
        if (hrdy !== 1'b1) begin
            check("ahb wait", n, 0);
            wrap_up();
        end
        q = hrdata;
        check("hready", {hrdy, hresp}, 2'h2);
    endtask : ahb
    // Fault line by index: low, high, hot, shutoff, overcurrent
    task automatic drive(input int k, input logic v);
        case (k)
            0: low_f <= v;
            1: high_f <= v;
            2: hot <= v;
            3: shut <= v;
            default: ovc <= v;
        endcase
    endtask : drive
    task automatic t_powerup();
        int n;
        repeat (3 * SD) @(posedge clk);
        check("held", gate, 1'b0);
        shut <= 1'b0;
        wait_for(0, 1'b1, SD + 40, n);
        check("start gap", n >= SD, 1'b1);
        wait_for(1, 1'b1, 60, n);
        check("pok_n", pok_n, 1'b0);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        check("state", rd[2:0], 3'h3);
        check("retry", rd[19:16], 4'h0);
        $display("t_powerup done");
    endtask : t_powerup
    task automatic t_filters();
        int flt [5] = '{10, 10, 5, 10, 20};
        int n;
        int t0;
        for (int k = 0; k < 5; k++) begin
            drive(k, 1'b1);
            repeat (flt[k] - 2) @(posedge clk);
            drive(k, 1'b0);
            repeat (5) @(posedge clk);
            check("glitch", pok, 1'b1);
            drive(k, 1'b1);
            wait_for(0, 1'b0, flt[k] + 6, n);
            t0 = cyc;
            check("dropped", pok, 1'b0);
            ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
            check("retry", rd[19:16], (k == 3) ? 4'h0 : 4'h1);
            repeat (4) @(posedge clk);
            drive(k, 1'b0);
            // Overcurrent retry delay runs from the drop, the rest from release
            if (k != 4) begin
                t0 = cyc;
            end
            wait_for(0, 1'b1, SD + 40, n);
            check("retry gap", cyc - t0 >= SD, 1'b1);
            wait_for(1, 1'b1, 60, n);
        end
        $display("t_filters done");
    endtask : t_filters
    task automatic t_limit();
        int n;
        shut <= 1'b1;
        wait_for(0, 1'b0, 20, n);
        stuck <= 1'b1;
        shut <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            wait_for(0, 1'b1, SD + 40, n);
            ovc <= 1'b1;
            wait_for(0, 1'b0, 30, n);
            ovc <= 1'b0;
        end
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        check("retry full", rd[19:16], 4'hA);
        repeat (2 * SD + 20) @(posedge clk);
        check("no restart", gate, 1'b0);
        ahb(1'b1, 32'h0000_0004, 32'h0000_0001, rd);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        check("control", rd, 32'h0000_0001);
        // A deselected write must leave the control bit alone
        hsel <= 1'b0;
        ahb(1'b1, 32'h0000_0004, 32'h0000_0000, rd);
        hsel <= 1'b1;
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        check("deselected", rd, 32'h0000_0001);
        repeat (15) @(posedge clk);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        check("cleared", rd[19:16], 4'h0);
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        stuck <= 1'b0;
        ahb(1'b1, 32'h0000_0004, 32'h0000_0000, rd);
        wait_for(0, 1'b1, SD + 40, n);
        wait_for(1, 1'b1, 60, n);
        $display("t_limit done");
    endtask : t_limit
    task automatic t_lockout();
        int n;
        lock_ok <= 1'b0;
        wait_for(0, 1'b0, 20, n);
        check("lock pok", pok, 1'b0);
        slow <= 1'b1;
        repeat (2 * SD) @(posedge clk);
        check("lock hold", gate, 1'b0);
        lock_ok <= 1'b1;
        wait_for(0, 1'b1, SD + 40, n);
        repeat (30) @(posedge clk);
        check("slow pok", pok, 1'b0);
        wait_for(1, 1'b1, 60, n);
        check("slow enh", enh, 1'b1);
        $display("t_lockout done");
    endtask : t_lockout
    initial begin
        {rst, lock_ok, shut} = 3'h7;
        {low_f, high_f, hot, ovc, slow, stuck, hwrite} = 7'h00;
        htrans = 2'h0;
        hsel   = 1'b1;
        hsize  = 3'h2;
        haddr  = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_powerup();
        t_filters();
        t_limit();
        t_lockout();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
